// ==== prox_regs.svh ====
// Register offsets, field positions, reset values and the persistence count limit of the
// proximity result and threshold register file.
// Assumes byte-wide registers at byte addresses, as seen through the serial port.
`ifndef PROX_REGS_SVH
`define PROX_REGS_SVH

`define PROX_LOW_THR_LO_ADDR 8'h10
`define PROX_LOW_THR_HI_ADDR 8'h11
`define PROX_HIGH_THR_LO_ADDR 8'h12
`define PROX_HIGH_THR_HI_ADDR 8'h13
`define XTALK_OFS_LO_ADDR 8'h14
`define XTALK_OFS_HI_ADDR 8'h15
`define AMB_SRC_SEL_ADDR 8'h16
`define ERR_FLAGS_ADDR 8'h17
`define PROX_RESULT_LO_ADDR 8'h18
`define PROX_RESULT_HI_ADDR 8'h19
`define IR_RESULT_LO_ADDR 8'h1a
`define IR_RESULT_HI_ADDR 8'h1b

`define PROX_LOW_THR_RESET 16'h0000
`define PROX_HIGH_THR_RESET 16'hffff
`define XTALK_OFS_RESET 16'h0000
`define AMB_SRC_SEL_RESET 1'h0

`define AMB_SRC_SEL_BIT 0
`define CHANNEL0_RANGE_ERROR_BIT 0
`define CHANNEL1_RANGE_ERROR_BIT 1
`define INFRARED_RANGE_ERROR_BIT 3

`define PERSIST_MAX 4'hf

`endif

// ==== prox_pkg.sv ====
// Types shared by the proximity result and threshold register file.
// Assumes the constants of prox_regs.svh are included where offsets are needed.
package prox_pkg;

  // One register access from the serial front end
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  // One finished proximity conversion
  typedef struct packed {
    logic [15:0] raw;
    logic [15:0] ir;
    logic ir_err;
  } prox_sample_t;

  // One finished ambient conversion
  typedef struct packed {
    logic [15:0] ch0;
    logic [15:0] ch1;
    logic ch0_err;
    logic ch1_err;
  } amb_sample_t;

  // Index of a latched result: proximity or infrared
  typedef enum logic {
    RES_PROX,
    RES_IR
  } result_idx_t;

endpackage

// ==== prox_result_threshold_regs.sv ====
// Proximity result, threshold, crosstalk offset, ambient source and error flag registers.
// Assumes a serial front end on CLK_SYS that issues one-cycle byte read/write strobes.
// Function
// - Proximity high threshold: 16 bits, two bytes, resets to all ones.
// - Proximity interrupt decision compares result against programmed thresholds.
// - Crosstalk offset is subtracted from each raw proximity count.
// - Crosstalk offset resets to zero, so result equals raw count.
// - Source bit 0 picks ambient channel 0 or 1 for ambient comparison.
// - Read-only error bits flag out-of-range channel 0, channel 1, infrared.
// - Each proximity conversion writes corrected result into proximity result.
// - Reading low byte freezes high byte until read; host reads low first.
// - Infrared result stored when each proximity conversion completes.
// - Proximity low threshold, 16 bits, resets to zero, also compared.
// - Selected ambient channel compared with ambient low and high thresholds.
// - Interrupt asserts after programmed 0..15 consecutive events; zero means always.
`include "prox_regs.svh"

module prox_result_threshold_regs (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  // Register access from the serial front end
  input wire prox_pkg::reg_req_t REG_REQ,
  output logic [7:0] REG_RDATA,
  // Conversion results from the converters
  input wire logic PROX_DONE,
  input wire prox_pkg::prox_sample_t PROX_SAMPLE,
  input wire logic AMB_DONE,
  input wire prox_pkg::amb_sample_t AMB_SAMPLE,
  // Settings held elsewhere in the register file
  input wire logic [3:0] PROX_PERSISTENCE_COUNT,
  input wire logic [15:0] AMB_LOW_THR,
  input wire logic [15:0] AMB_HIGH_THR,
  // Interrupt decisions
  output logic PROX_IRQ,
  output logic AMB_EVENT
);

  logic [15:0] low_thr_reg;
  logic [15:0] high_thr_reg;
  logic [15:0] ofs_reg;
  logic src_sel_reg;
  logic [7:0] err_reg;
  logic [15:0] result_reg [2];
  logic [7:0] hi_hold_reg [2];
  logic frozen_reg [2];
  logic [3:0] persist_reg;
  logic [7:0] rdata_reg;
  logic prox_irq_reg;
  logic amb_event_reg;

  // Offset correction, clamped at zero when the offset exceeds the count
  wire logic [16:0] diff = {1'b0, PROX_SAMPLE.raw} - {1'b0, ofs_reg};
  wire logic [15:0] corrected = diff[16] ? 16'h0000 : diff[15:0];

  wire logic prox_event = (corrected > high_thr_reg) || (corrected < low_thr_reg);
  wire logic [3:0] persist_next = (persist_reg == `PERSIST_MAX) ? persist_reg : persist_reg + 4'h1;
  wire logic prox_irq_next = (PROX_PERSISTENCE_COUNT == 4'h0) ? 1'b1 :
                             (prox_event && persist_next >= PROX_PERSISTENCE_COUNT);

  wire logic [15:0] amb_sel = src_sel_reg ? AMB_SAMPLE.ch1 : AMB_SAMPLE.ch0;
  wire logic amb_event_next = (amb_sel > AMB_HIGH_THR) || (amb_sel < AMB_LOW_THR);

  wire logic wr = REG_REQ.wr;
  wire logic rd = REG_REQ.rd;
  wire logic [7:0] addr = REG_REQ.addr;
  wire logic [7:0] wd = REG_REQ.wdata;

  wire logic rd_lo [2];
  wire logic rd_hi [2];
  wire logic [7:0] hi_view [2];
  assign rd_lo[0] = rd && addr == `PROX_RESULT_LO_ADDR;
  assign rd_hi[0] = rd && addr == `PROX_RESULT_HI_ADDR;
  assign rd_lo[1] = rd && addr == `IR_RESULT_LO_ADDR;
  assign rd_hi[1] = rd && addr == `IR_RESULT_HI_ADDR;
  assign hi_view[0] = frozen_reg[0] ? hi_hold_reg[0] : result_reg[0][15:8];
  assign hi_view[1] = frozen_reg[1] ? hi_hold_reg[1] : result_reg[1][15:8];

  logic [7:0] rdata_next;
  always_comb begin
    case (addr)
      `PROX_LOW_THR_LO_ADDR: rdata_next = low_thr_reg[7:0];
      `PROX_LOW_THR_HI_ADDR: rdata_next = low_thr_reg[15:8];
      `PROX_HIGH_THR_LO_ADDR: rdata_next = high_thr_reg[7:0];
      `PROX_HIGH_THR_HI_ADDR: rdata_next = high_thr_reg[15:8];
      `XTALK_OFS_LO_ADDR: rdata_next = ofs_reg[7:0];
      `XTALK_OFS_HI_ADDR: rdata_next = ofs_reg[15:8];
      `AMB_SRC_SEL_ADDR: rdata_next = {7'h00, src_sel_reg};
      `ERR_FLAGS_ADDR: rdata_next = err_reg;
      `PROX_RESULT_LO_ADDR: rdata_next = result_reg[0][7:0];
      `PROX_RESULT_HI_ADDR: rdata_next = hi_view[0];
      `IR_RESULT_LO_ADDR: rdata_next = result_reg[1][7:0];
      `IR_RESULT_HI_ADDR: rdata_next = hi_view[1];
      default: rdata_next = 8'h00;
    endcase
  end

  // Writable settings
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      low_thr_reg <= `PROX_LOW_THR_RESET;
      high_thr_reg <= `PROX_HIGH_THR_RESET;
      ofs_reg <= `XTALK_OFS_RESET;
      src_sel_reg <= `AMB_SRC_SEL_RESET;
    end else if (wr) begin
      case (addr)
        `PROX_LOW_THR_LO_ADDR: low_thr_reg[7:0] <= wd;
        `PROX_LOW_THR_HI_ADDR: low_thr_reg[15:8] <= wd;
        `PROX_HIGH_THR_LO_ADDR: high_thr_reg[7:0] <= wd;
        `PROX_HIGH_THR_HI_ADDR: high_thr_reg[15:8] <= wd;
        `XTALK_OFS_LO_ADDR: ofs_reg[7:0] <= wd;
        `XTALK_OFS_HI_ADDR: ofs_reg[15:8] <= wd;
        `AMB_SRC_SEL_ADDR: src_sel_reg <= wd[`AMB_SRC_SEL_BIT];
        default: src_sel_reg <= src_sel_reg;
      endcase
    end
  end

  // Results, error flags and read data
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      result_reg[0] <= 16'h0000;
      result_reg[1] <= 16'h0000;
      err_reg <= 8'h00;
      rdata_reg <= 8'h00;
    end else begin
      if (PROX_DONE) begin
        result_reg[prox_pkg::RES_PROX] <= corrected;
        result_reg[prox_pkg::RES_IR] <= PROX_SAMPLE.ir;
        err_reg[`INFRARED_RANGE_ERROR_BIT] <= PROX_SAMPLE.ir_err;
      end
      if (AMB_DONE) begin
        err_reg[`CHANNEL0_RANGE_ERROR_BIT] <= AMB_SAMPLE.ch0_err;
        err_reg[`CHANNEL1_RANGE_ERROR_BIT] <= AMB_SAMPLE.ch1_err;
      end
      if (rd) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // High byte freeze between low and high byte reads
  for (genvar i = 0; i < 2; i++) begin : g_latch
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
        frozen_reg[i] <= 1'b0;
        hi_hold_reg[i] <= 8'h00;
      end else if (rd_lo[i]) begin
        frozen_reg[i] <= 1'b1;
        hi_hold_reg[i] <= result_reg[i][15:8];
      end else if (rd_hi[i]) begin
        frozen_reg[i] <= 1'b0;
      end
    end
  end

  // Interrupt decisions
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      persist_reg <= 4'h0;
      prox_irq_reg <= 1'b0;
      amb_event_reg <= 1'b0;
    end else begin
      if (PROX_DONE) begin
        persist_reg <= prox_event ? persist_next : 4'h0;
        prox_irq_reg <= prox_irq_next;
      end
      if (AMB_DONE) begin
        amb_event_reg <= amb_event_next;
      end
    end
  end

  assign REG_RDATA = rdata_reg;
  assign PROX_IRQ = prox_irq_reg;
  assign AMB_EVENT = amb_event_reg;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);

  chk_result_offset_store: assert property (
    PROX_DONE |=> result_reg[0] == (($past(PROX_SAMPLE.raw) >= $past(ofs_reg)) ?
      $past(PROX_SAMPLE.raw) - $past(ofs_reg) : 16'h0000))
    else $error("proximity result not offset corrected");
  chk_ir_store: assert property (
    PROX_DONE |=> result_reg[1] == $past(PROX_SAMPLE.ir))
    else $error("infrared result not stored");
  chk_result_hold: assert property (
    !PROX_DONE |=> $stable(result_reg[0]))
    else $error("proximity result changed without conversion");
  chk_high_freeze: assert property (
    (rd_lo[0] ##1 (!rd_hi[0] && !rd_lo[0]) ##1 rd_hi[0]) |=>
      REG_RDATA == $past(result_reg[0][15:8], 3))
    else $error("high byte not frozen after low byte read");
  chk_freeze_release: assert property (
    rd_hi[1] && !rd_lo[1] |=> !frozen_reg[1])
    else $error("high byte stays frozen after its read");
  chk_zero_persist: assert property (
    PROX_DONE && PROX_PERSISTENCE_COUNT == 4'h0 |=> PROX_IRQ)
    else $error("zero persistence did not assert interrupt");
  chk_no_event_irq: assert property (
    PROX_DONE && !prox_event && PROX_PERSISTENCE_COUNT != 4'h0 |=> !PROX_IRQ && persist_reg == 4'h0)
    else $error("interrupt without threshold event");
  chk_amb_source: assert property (
    AMB_DONE |=> AMB_EVENT == (($past(src_sel_reg) ? $past(AMB_SAMPLE.ch1) : $past(AMB_SAMPLE.ch0))
      > $past(AMB_HIGH_THR) || ($past(src_sel_reg) ? $past(AMB_SAMPLE.ch1) :
      $past(AMB_SAMPLE.ch0)) < $past(AMB_LOW_THR)))
    else $error("ambient event from wrong channel");
  chk_err_flags: assert property (
    AMB_DONE |=> err_reg[`CHANNEL1_RANGE_ERROR_BIT] == $past(AMB_SAMPLE.ch1_err) && err_reg[7:4] == 4'h0)
    else $error("channel 1 error flag wrong");
  chk_high_thr_write: assert property (
    wr && addr == `PROX_HIGH_THR_HI_ADDR |=> high_thr_reg[15:8] == $past(wd))
    else $error("high threshold high byte not written");
  chk_ir_err_flag: assert property (
    PROX_DONE |=> err_reg[`INFRARED_RANGE_ERROR_BIT] == $past(PROX_SAMPLE.ir_err) && err_reg[2] == 1'b0)
    else $error("infrared error flag wrong");
  chk_ch0_err_flag: assert property (
    AMB_DONE |=> err_reg[`CHANNEL0_RANGE_ERROR_BIT] == $past(AMB_SAMPLE.ch0_err))
    else $error("channel 0 error flag wrong");

endmodule

// ==== prox_host_model.sv ====
// Register host model: byte reads and writes on the register request port.
// Assumes each access starts just after a rising clock edge.
module prox_host_model (
  // Clock
  input wire logic CLK_SYS,
  // Register port
  output prox_pkg::reg_req_t REG_REQ,
  input wire logic [7:0] REG_RDATA
);
  timeunit 1ns;
  timeprecision 100ps;
  initial REG_REQ = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_REQ = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge CLK_SYS);
    #1 REG_REQ = '0;
    @(posedge CLK_SYS);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    REG_REQ = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge CLK_SYS);
    #1 REG_REQ = '0;
    @(posedge CLK_SYS);
    #1 d = REG_RDATA;
  endtask
  // Low byte first so both bytes come from one measurement
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 8'h01, d[15:8]);
  endtask
endmodule

// ==== prox_result_threshold_regs_tb.sv ====
// Self-checking bench for the proximity result and threshold register file.
// Assumes prox_pkg and prox_host_model are compiled first.
module prox_result_threshold_regs_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  prox_pkg::reg_req_t reg_req;
  logic [7:0] reg_rdata;
  logic prox_done = 1'b0;
  prox_pkg::prox_sample_t prox_sample = '0;
  logic amb_done = 1'b0;
  prox_pkg::amb_sample_t amb_sample = '0;
  logic [3:0] persist = 4'h0;
  logic [15:0] amb_lo = 16'h0100;
  logic [15:0] amb_hi = 16'h0200;
  logic prox_irq;
  logic amb_event;
  logic [7:0] b;
  int mismatches = 0;
  int n_tests = 0;
  always #2 clk_sys = ~clk_sys;
  prox_result_threshold_regs u_prox_result_threshold_regs (.CLK_SYS(clk_sys), .ARST_N(arst_n),
    .REG_REQ(reg_req), .REG_RDATA(reg_rdata), .PROX_DONE(prox_done), .PROX_SAMPLE(prox_sample),
    .AMB_DONE(amb_done), .AMB_SAMPLE(amb_sample), .PROX_PERSISTENCE_COUNT(persist),
    .AMB_LOW_THR(amb_lo), .AMB_HIGH_THR(amb_hi), .PROX_IRQ(prox_irq), .AMB_EVENT(amb_event));
  prox_host_model u_prox_host_model (.CLK_SYS(clk_sys), .REG_REQ(reg_req),
    .REG_RDATA(reg_rdata));
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_prox_host_model.wr(a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    u_prox_host_model.rd(a, b);
    chk16({8'h00, b}, {8'h00, e});
  endtask
  task automatic rd16_chk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] w;
    u_prox_host_model.rd16(a, w);
    chk16(w, e);
  endtask
  task automatic prox(input logic [15:0] raw, input logic [15:0] ir, input logic err);
    prox_done = 1'b1;
    prox_sample = '{raw: raw, ir: ir, ir_err: err};
    tick;
    prox_done = 1'b0;
    tick;
  endtask
  task automatic amb(input logic [15:0] c0, input logic [15:0] c1, input logic e0,
                     input logic e1);
    amb_done = 1'b1;
    amb_sample = '{ch0: c0, ch1: c1, ch0_err: e0, ch1_err: e1};
    tick;
    amb_done = 1'b0;
    tick;
  endtask
  task automatic end_sim;
    if (mismatches == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    end_sim;
  end
  initial begin
    repeat (5) @(posedge clk_sys);
    #1 arst_n = 1'b1;
    rd_chk(8'h10, 8'h00);
    rd_chk(8'h11, 8'h00);
    rd_chk(8'h12, 8'hff);
    rd_chk(8'h13, 8'hff);
    rd_chk(8'h14, 8'h00);
    rd_chk(8'h15, 8'h00);
    rd_chk(8'h16, 8'h00);
    wr(8'h17, 8'hff);
    rd_chk(8'h17, 8'h00);
    rd_chk(8'h30, 8'h00);
    prox(16'h1234, 16'hbeef, 1'b0);
    chk1(prox_irq, 1'b1);
    rd16_chk(8'h18, 16'h1234);
    rd16_chk(8'h1a, 16'hbeef);
    wr(8'h15, 8'h01);
    rd_chk(8'h15, 8'h01);
    prox(16'h1234, 16'h0042, 1'b1);
    rd16_chk(8'h18, 16'h1134);
    rd_chk(8'h17, 8'h08);
    prox(16'h00ff, 16'h0001, 1'b0);
    rd16_chk(8'h18, 16'h0000);
    rd_chk(8'h17, 8'h00);
    // New conversion between low and high byte reads
    prox(16'h3456, 16'h7788, 1'b0);
    rd_chk(8'h18, 8'h56);
    prox(16'h5678, 16'h99aa, 1'b0);
    rd_chk(8'h19, 8'h33);
    rd_chk(8'h1b, 8'h99);
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h40);
    rd_chk(8'h13, 8'h40);
    wr(8'h11, 8'h10);
    rd_chk(8'h11, 8'h10);
    persist = 4'h2;
    prox(16'h2100, 16'h0000, 1'b0);
    chk1(prox_irq, 1'b0);
    prox(16'h5100, 16'h0000, 1'b0);
    chk1(prox_irq, 1'b0);
    prox(16'h5100, 16'h0000, 1'b0);
    chk1(prox_irq, 1'b1);
    // A conversion inside the thresholds restarts the consecutive count
    prox(16'h2100, 16'h0000, 1'b0);
    chk1(prox_irq, 1'b0);
    prox(16'h0200, 16'h0000, 1'b0);
    chk1(prox_irq, 1'b0);
    prox(16'h0200, 16'h0000, 1'b0);
    chk1(prox_irq, 1'b1);
    prox(16'h2100, 16'h0000, 1'b0);
    chk1(prox_irq, 1'b0);
    wr(8'h16, 8'hff);
    rd_chk(8'h16, 8'h01);
    amb(16'h0150, 16'h0050, 1'b1, 1'b0);
    chk1(amb_event, 1'b1);
    rd_chk(8'h17, 8'h01);
    wr(8'h16, 8'h00);
    amb(16'h0150, 16'h0050, 1'b0, 1'b1);
    chk1(amb_event, 1'b0);
    rd_chk(8'h17, 8'h02);
    amb(16'h0250, 16'h0150, 1'b1, 1'b1);
    chk1(amb_event, 1'b1);
    rd_chk(8'h17, 8'h03);
    end_sim;
  end
endmodule
